// file: hdl/wdt_consts.svh
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH

// special function address of the key register
`define WDT_KEY_ADDR        8'ha6
// key bytes, first then second
`define WDT_KEY_FIRST       8'h1e
`define WDT_KEY_SECOND      8'he1
// counter width and overflow value
`define WDT_CNT_W           14
`define WDT_CNT_MAX         14'h3fff
`define WDT_CNT_ZERO        14'h0000
`define WDT_CNT_ONE         14'h0001
// oscillator periods per machine cycle
`define WDT_MC_6CLK         4'h6
`define WDT_MC_12CLK        4'hc
`define WDT_DIV_ONE         4'h1
// reset pulse length in oscillator periods
`define WDT_PULSE_6CLK_TOSC  98
`define WDT_PULSE_12CLK_TOSC 196
// oscillator period and system clock period in ns
`define WDT_OSC_PERIOD_NS   50
`define WDT_CLK_PERIOD_NS   50
// pulse lengths in clk cycles
`define WDT_PULSE_6CLK_CYC  8'((`WDT_PULSE_6CLK_TOSC * `WDT_OSC_PERIOD_NS) / `WDT_CLK_PERIOD_NS)
`define WDT_PULSE_12CLK_CYC 8'((`WDT_PULSE_12CLK_TOSC * `WDT_OSC_PERIOD_NS) / `WDT_CLK_PERIOD_NS)
`define WDT_PULSE_ZERO      8'h00
`define WDT_PULSE_ONE       8'h01
`define WDT_READ_VALUE      8'h00
`define WDT_SYNC_RESET      3'h0

`endif

// file: hdl/wdt_pkg.sv
package wdt_pkg;

    // key sequence tracker
    typedef enum logic [0:0] {
        KEY_IDLE,
        KEY_GOT_FIRST
    } key_state_t;

    // whole state of the watchdog
    typedef struct packed {
        key_state_t  key;
        logic        armed;
        logic [13:0] count;
        logic [7:0]  pulse_cnt;
        logic        pin_out;
        logic        pin_oe_n;
        logic        dev_rst;
        logic [7:0]  rdata;
        logic [2:0]  pin_sync;
        logic        pin_rst;
        logic        twelve;
    } wd_state_t;

    // state of the machine cycle divider
    typedef struct packed {
        logic [3:0] div_cnt;
        logic       tick;
    } tick_state_t;

endpackage

// file: hdl/tick_if.sv
`timescale 1ns/10ps
interface tick_if;
    logic tick;
    logic run;
    logic twelve;

    modport src  (output tick, input run, input twelve);
    modport sink (input tick, output run, output twelve);
endinterface

// file: hdl/machine_tick.sv
`timescale 1ns/10ps
`include "wdt_consts.svh"
module machine_tick
    import wdt_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // tick towards the watchdog
    tick_if.src      mc
);

    tick_state_t state_reg;
    tick_state_t state_next;
    logic [3:0]  period;

    // one tick per six or twelve oscillator periods
    always_comb begin
        state_next = state_reg;
        period = mc.twelve ? `WDT_MC_12CLK : `WDT_MC_6CLK;
        state_next.tick = 1'b0;
        if (!mc.run) begin
            state_next.div_cnt = `WDT_DIV_ONE;
        end else if (state_reg.div_cnt >= period) begin
            state_next.div_cnt = `WDT_DIV_ONE;
            state_next.tick = 1'b1;
        end else begin
            state_next.div_cnt = 4'(state_reg.div_cnt + `WDT_DIV_ONE);
        end
    end

    // state register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign mc.tick = state_reg.tick;

    // ticks never come closer than one short machine cycle
    a_tick_gap: assert property (@(posedge clk) disable iff (!rstn)
        state_reg.tick |=> !state_reg.tick [*5])
        else $error("machine ticks too close");

    // six clock mode: next tick six cycles after the last
    a_tick_six: assert property (@(posedge clk) disable iff (!rstn)
        (state_reg.tick && mc.run && !mc.twelve) ##1 (mc.run && !mc.twelve) [*5] |=> state_reg.tick)
        else $error("six clock tick spacing wrong");

    // twelve clock mode: next tick twelve cycles after the last
    a_tick_twelve: assert property (@(posedge clk) disable iff (!rstn)
        (state_reg.tick && mc.run && mc.twelve) ##1 (mc.run && mc.twelve) [*8] ##1 (mc.run && mc.twelve) [*3]
        |=> state_reg.tick)
        else $error("twelve clock tick spacing wrong");

endmodule // machine_tick

// file: hdl/oneshot_enable_watchdog.sv
// Overview of operation
// - fourteen bit counter with one key register
// - every reset leaves the watchdog disarmed
// - key pair at a6 arms the watchdog
// - armed counter steps once per machine cycle
// - no software disarm, only resets disarm
// - reaching 3fff resets the whole device
// - key pair while armed clears counter
// - key register is write only
// - counter never readable nor loadable
// - overflow drives high pulse on reset pin
// - pulse lasts 98 or 196 oscillator periods
`timescale 1ns/10ps
`include "wdt_consts.svh"
module oneshot_enable_watchdog
    import wdt_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // special function register port
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic [7:0] sfr_addr,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata,
    // configuration
    input  wire logic       twelve_clk_mode,
    // reset pin, two-way
    input  wire logic       rst_pin_in,
    output logic            rst_pin_out,
    output logic            rst_pin_oe_n,
    // reset towards the rest of the device
    output logic            device_reset
);

    wd_state_t state_reg;
    wd_state_t state_next;
    tick_if    mc ();

    logic key_wr;
    logic accept;
    logic service;
    logic overflow;
    logic in_reset;

    // write strobe aimed at the key register
    function automatic logic key_hit(input logic wr, input logic [7:0] addr);
        return wr && (addr == `WDT_KEY_ADDR);
    endfunction

    // machine cycle divider
    machine_tick u_tick (
        .clk  (clk),
        .rstn (rstn),
        .mc   (mc.src)
    );

    assign mc.run    = state_reg.armed;
    assign mc.twelve = state_reg.twelve;

    // key decode and overflow detection
    always_comb begin
        in_reset = state_reg.dev_rst;
        key_wr   = key_hit(sfr_wr, sfr_addr) && !in_reset;
        accept   = key_wr && (state_reg.key == KEY_GOT_FIRST) && (sfr_wdata == `WDT_KEY_SECOND);
        service  = state_reg.armed && accept;
        overflow = state_reg.armed && (state_reg.count == `WDT_CNT_MAX) && !service;
    end

    // next state
    always_comb begin
        state_next = state_reg;
        state_next.twelve = twelve_clk_mode;

        // pin synchroniser, level taken once the last two agree
        state_next.pin_sync = {state_reg.pin_sync[1:0], rst_pin_in};
        if (state_reg.pin_sync[1] == state_reg.pin_sync[2]) begin
            state_next.pin_rst = state_reg.pin_sync[2];
        end

        // key sequence tracker
        if (in_reset) begin
            state_next.key = KEY_IDLE;
        end else if (key_wr) begin
            if (sfr_wdata == `WDT_KEY_FIRST) begin
                state_next.key = KEY_GOT_FIRST;
            end else begin
                state_next.key = KEY_IDLE;
            end
        end

        // arming, counting, servicing; no load path exists
        if (in_reset || overflow) begin
            state_next.armed = 1'b0;
            state_next.count = `WDT_CNT_ZERO;
        end else if (accept) begin
            state_next.armed = 1'b1;
            state_next.count = `WDT_CNT_ZERO;
        end else if (state_reg.armed && mc.tick) begin
            state_next.count = 14'(state_reg.count + `WDT_CNT_ONE);
        end

        // reset pulse on the pin
        if (overflow) begin
            state_next.pulse_cnt = state_reg.twelve ? `WDT_PULSE_12CLK_CYC : `WDT_PULSE_6CLK_CYC;
        end else if (state_reg.pulse_cnt != `WDT_PULSE_ZERO) begin
            state_next.pulse_cnt = 8'(state_reg.pulse_cnt - `WDT_PULSE_ONE);
        end
        state_next.pin_out  = (state_next.pulse_cnt != `WDT_PULSE_ZERO);
        state_next.pin_oe_n = !state_next.pin_out;
        state_next.dev_rst  = state_next.pin_out || state_reg.pin_rst;

        // key register reads back nothing
        state_next.rdata = `WDT_READ_VALUE;
    end

    // state register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg          <= '0;
            state_reg.key      <= KEY_IDLE;
            state_reg.pin_oe_n <= 1'b1;
            state_reg.pin_sync <= `WDT_SYNC_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs straight from flip-flops
    assign sfr_rdata    = state_reg.rdata;
    assign rst_pin_out  = state_reg.pin_out;
    assign rst_pin_oe_n = state_reg.pin_oe_n;
    assign device_reset = state_reg.dev_rst;

    // helper: length of the current pin pulse
    logic [8:0] hi_len;
    logic       hi_twelve;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hi_len    <= 9'h000;
            hi_twelve <= 1'b0;
        end else if (state_reg.pin_out) begin
            hi_len    <= 9'(hi_len + 9'h001);
        end else begin
            hi_len    <= 9'h000;
            hi_twelve <= state_reg.twelve;
        end
    end

    a_disarmed_zero: assert property (@(posedge clk) disable iff (!rstn)
        !state_reg.armed |-> state_reg.count == `WDT_CNT_ZERO)
        else $error("disarmed counter not zero");

    a_arm_on_pair: assert property (@(posedge clk) disable iff (!rstn)
        (key_hit(sfr_wr, sfr_addr) && !state_reg.dev_rst && state_reg.key == KEY_GOT_FIRST
         && sfr_wdata == `WDT_KEY_SECOND) |=> state_reg.armed && state_reg.count == `WDT_CNT_ZERO)
        else $error("key pair did not arm");

    a_count_step: assert property (@(posedge clk) disable iff (!rstn)
        (state_reg.armed && mc.tick && !overflow && !accept && !in_reset)
        |=> state_reg.count == 14'($past(state_reg.count) + `WDT_CNT_ONE))
        else $error("counter did not step on tick");

    a_stay_armed: assert property (@(posedge clk) disable iff (!rstn)
        (state_reg.armed && !overflow && !state_reg.dev_rst) |=> state_reg.armed)
        else $error("watchdog disarmed without reset");

    a_overflow_rst: assert property (@(posedge clk) disable iff (!rstn)
        (state_reg.armed && state_reg.count == `WDT_CNT_MAX && !accept)
        |=> !state_reg.armed && device_reset && rst_pin_out && !rst_pin_oe_n)
        else $error("overflow did not reset device");

    a_service_clr: assert property (@(posedge clk) disable iff (!rstn)
        (state_reg.armed && accept) |=> state_reg.armed && state_reg.count == `WDT_CNT_ZERO)
        else $error("service did not clear counter");

    a_read_blank: assert property (@(posedge clk) disable iff (!rstn)
        $past(sfr_rd) |-> sfr_rdata == `WDT_READ_VALUE)
        else $error("key register read back data");

    a_pulse_len: assert property (@(posedge clk) disable iff (!rstn)
        $fell(state_reg.pin_out) |-> hi_len == (hi_twelve ? 9'(`WDT_PULSE_12CLK_CYC) : 9'(`WDT_PULSE_6CLK_CYC)))
        else $error("reset pulse length wrong");

    a_bad_key: assert property (@(posedge clk) disable iff (!rstn)
        (key_hit(sfr_wr, sfr_addr) && !state_reg.armed && !state_reg.dev_rst
         && sfr_wdata != `WDT_KEY_SECOND) |=> !state_reg.armed)
        else $error("wrong key armed watchdog");

    // pin is driven exactly while a pulse is pending
    a_pin_drive: assert property (@(posedge clk) disable iff (!rstn)
        (state_reg.pulse_cnt != `WDT_PULSE_ZERO) == (rst_pin_out && !rst_pin_oe_n))
        else $error("reset pin drive wrong");

    // device held in reset while the pin pulse runs
    a_pulse_resets: assert property (@(posedge clk) disable iff (!rstn)
        rst_pin_out |-> device_reset)
        else $error("pulse without device reset");

    // any reset level disarms on the next cycle
    a_reset_disarm: assert property (@(posedge clk) disable iff (!rstn)
        state_reg.dev_rst |=> !state_reg.armed)
        else $error("still armed during reset");

    // a key write other than the first byte drops the tracker
    a_key_drop: assert property (@(posedge clk) disable iff (!rstn)
        (key_wr && sfr_wdata != `WDT_KEY_FIRST) |=> state_reg.key == KEY_IDLE)
        else $error("key tracker not cleared");

    // the first byte always starts a new pair
    a_key_start: assert property (@(posedge clk) disable iff (!rstn)
        (key_wr && sfr_wdata == `WDT_KEY_FIRST) |=> state_reg.key == KEY_GOT_FIRST)
        else $error("key tracker not started");

    // counter moves only by a tick or a clear
    a_count_only: assert property (@(posedge clk) disable iff (!rstn)
        (state_reg.count != $past(state_reg.count)) |-> (state_reg.count == `WDT_CNT_ZERO || $past(mc.tick)))
        else $error("counter changed without tick or clear");

endmodule // oneshot_enable_watchdog

// file: verif/testbench.sv
`timescale 1ns/10ps
`include "wdt_consts.svh"
module testbench
    import wdt_pkg::*;
;
    // one ordinary case: a bus access and the read data it should give
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] data;
        logic [7:0] exp_rdata;
    } row_t;

    localparam int mc_len    = 6;
    localparam int pulse_len = 98;
    localparam int limit     = 105000;

    logic       clk;
    logic       rstn;
    logic       sfr_wr;
    logic       sfr_rd;
    logic [7:0] sfr_addr;
    logic [7:0] sfr_wdata;
    logic [7:0] sfr_rdata;
    logic       twelve_clk_mode;
    logic       ext_rst;
    wire logic  rst_pin_in;
    logic       rst_pin_out;
    logic       rst_pin_oe_n;
    logic       device_reset;
    int         err_total;
    int         n_checks;
    int         cyc = 0;
    int         svc;
    int         n;
    row_t       rows [9];

    // bad key sequences mixed with reads; none may service
    assign rows = '{'{1'b1, 1'b0, 8'ha6, 8'h1e, 8'h00}, '{1'b1, 1'b0, 8'ha6, 8'h00, 8'h00},
                    '{1'b1, 1'b0, 8'ha6, 8'he1, 8'h00}, '{1'b0, 1'b1, 8'ha6, 8'h00, 8'h00},
                    '{1'b1, 1'b0, 8'ha6, 8'he1, 8'h00}, '{1'b1, 1'b0, 8'ha6, 8'h1e, 8'h00},
                    '{1'b1, 1'b0, 8'ha5, 8'he1, 8'h00}, '{1'b1, 1'b0, 8'ha6, 8'h55, 8'h00},
                    '{1'b0, 1'b1, 8'ha6, 8'h00, 8'h00}};

    // reset pin: pull-down, our drive, or an outside reset
    assign rst_pin_in = (~rst_pin_oe_n & rst_pin_out) | ext_rst;

    oneshot_enable_watchdog u_oneshot_enable_watchdog (
        .clk             (clk),
        .rstn            (rstn),
        .sfr_wr          (sfr_wr),
        .sfr_rd          (sfr_rd),
        .sfr_addr        (sfr_addr),
        .sfr_wdata       (sfr_wdata),
        .sfr_rdata       (sfr_rdata),
        .twelve_clk_mode (twelve_clk_mode),
        .rst_pin_in      (rst_pin_in),
        .rst_pin_out     (rst_pin_out),
        .rst_pin_oe_n    (rst_pin_oe_n),
        .device_reset    (device_reset)
    );

    // clock
    always #25 clk = ~clk;

    // cycle count and hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == limit) begin
            err_total++;
            final_report();
        end
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_wr    <= 1'b1;
        sfr_addr  <= a;
        sfr_wdata <= d;
        @(posedge clk);
        sfr_wr <= 1'b0;
    endtask

    task automatic key_pair();
        wr(`WDT_KEY_ADDR, `WDT_KEY_FIRST);
        wr(`WDT_KEY_ADDR, `WDT_KEY_SECOND);
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // main sequence
    initial begin
        clk = 1'b0; rstn = 1'b0; sfr_wr = 1'b0; sfr_rd = 1'b0; sfr_addr = 8'h00; sfr_wdata = 8'h00;
        twelve_clk_mode = 1'b0; ext_rst = 1'b0; err_total = 0; n_checks = 0;
        repeat (19) @(posedge clk);
        #1;
        check(sfr_rdata, 8'h00, "rdata in reset");
        check({7'h00, rst_pin_oe_n}, 8'h01, "pin released in reset");
        check({7'h00, device_reset}, 8'h00, "device reset in reset");
        @(posedge clk);
        rstn <= 1'b1;
        // outside reset on the pin reaches the device
        @(posedge clk);
        ext_rst <= 1'b1;
        repeat (6) @(posedge clk);
        #1 check({7'h00, device_reset}, 8'h01, "pin reset seen");
        @(posedge clk);
        ext_rst <= 1'b0;
        repeat (6) @(posedge clk);
        #1 check({7'h00, device_reset}, 8'h00, "pin reset gone");
        // arm in twelve clock mode, then service once in six clock mode
        @(posedge clk);
        twelve_clk_mode <= 1'b1;
        key_pair();
        repeat (1000) @(posedge clk);
        twelve_clk_mode <= 1'b0;
        repeat (4) @(posedge clk);
        key_pair();
        svc = cyc;
        // bad sequences and reads
        foreach (rows[i]) begin
            @(posedge clk);
            sfr_wr    <= rows[i].wr;
            sfr_rd    <= rows[i].rd;
            sfr_addr  <= rows[i].addr;
            sfr_wdata <= rows[i].data;
            @(posedge clk);
            sfr_wr <= 1'b0;
            sfr_rd <= 1'b0;
            @(posedge clk);
            #1 check(sfr_rdata, rows[i].exp_rdata, "read data");
        end
        // overflow must follow the one good service
        n = 0;
        while (rst_pin_out !== 1'b1 && n < 100000) begin
            @(posedge clk);
            #1 n++;
        end
        n = (cyc >= svc + 16382 * mc_len) && (cyc <= svc + 16384 * mc_len + 4);
        check(n[7:0], 8'h01, "overflow time");
        check({7'h00, rst_pin_oe_n}, 8'h00, "pin driven");
        check({7'h00, device_reset}, 8'h01, "device reset on overflow");
        // pulse length
        n = 0;
        while (rst_pin_out === 1'b1 && n < 300) begin
            n++;
            @(posedge clk);
            #1;
        end
        check(n[7:0], pulse_len[7:0], "pulse length");
        check({7'h00, rst_pin_oe_n}, 8'h01, "pin released after pulse");
        repeat (8) @(posedge clk);
        #1 check({7'h00, device_reset}, 8'h00, "device reset ends");
        final_report();
    end
endmodule // testbench
